// File: rtl/fld_lock_detector.sv
// FLL lock and loss-of-lock detector with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module fld_lock_detector
   import fld_pkg::*;
(
   input  wire logic        sys_clk_in,               // 100 MHz system clock
   input  wire logic        nrst_in,                  // Asynchronous reset, active low
   input  wire logic        osc_pulse_in,             // One pulse per oscillator clock edge
   input  wire logic        ref_tick_in,              // End of one comparison cycle
   input  wire logic        stop_mode_in,             // MCU in stop mode
   input  wire logic [3:0]  avs_address,              // Byte address
   input  wire logic        avs_read,                 // Read request
   input  wire logic        avs_write,                // Write request
   input  wire logic [31:0] avs_writedata,            // Write data
   output logic [31:0]      avs_readdata,             // Read data
   output logic             avs_waitrequest,          // Stall while high
   output logic             lock_out,                 // Live lock indicator
   output logic             loss_of_lock_status_out,  // Sticky loss-of-lock status
   output logic             generated_output_clock_out, // Output clock enable pulse
   output logic             half_rate_out,            // Output divides by 2R
   output logic signed [15:0] filter_value_out,       // Digital loop filter value
   output logic             lol_reset_out,            // Loss-of-lock reset request pulse
   output logic             irq_out                   // Level interrupt
);

   fld_state_e         state;            // Detector state
   logic [31:0]        ctrl;             // Control register
   fld_ctrl_s          cfg;              // Decoded control fields
   logic [1:0]         stat;             // Sticky event bits
   logic [1:0]         mask;             // Interrupt mask
   logic               lost;             // Loss-of-lock status
   logic               stat_read_armed;  // Status read seen since last clear
   logic               first_locked;     // Lock reached since entering engaged mode
   logic [11:0]        pulse_cnt;        // Oscillator pulses this comparison
   logic signed [15:0] count_err;        // Last count error
   logic               sample_valid;     // One cycle after a new error
   logic [3:0]         in_lock_run;      // Consecutive samples inside lock window
   logic signed [17:0] avg_acc;          // Sum of errors for averaging
   logic [1:0]         avg_cnt;          // Samples in the running average
   logic [8:0]         div_cnt;          // Output divider position
   logic               stop_dbg_armed;   // Stop entered with debug enabled
   logic               stop_wake_lol;    // Debug dropped during stop
   logic               stop_d;           // Stop mode, one cycle late
   logic               bus_go;           // Access completes this edge
   logic               engaged;          // Loop in an engaged mode
   logic               stop_off;         // Generator off because of stop
   logic               in_lock_win;      // Error inside lock window
   logic               in_unlock_win;    // Error inside unlock window
   logic               expected_loss;    // Software changed loop settings
   logic               unexpected_loss;  // Error left the unlock window
   logic               wake_loss;        // Woke after debug dropped in stop
   logic               lost_set;         // Any unexpected loss event
   logic               lost_clear;       // Software clear of loss-of-lock
   logic               st_w1c;           // Write to status register one
   logic [31:0]        next_ctrl;        // Control value after a write
   logic signed [15:0] next_err;         // Error for the current comparison
   logic [8:0]         div_target;       // Oscillator pulses per output period

   assign cfg     = fld_ctrl_s'({ctrl[31:24], ctrl[20:8], ctrl[6:0]});
   assign bus_go  = (avs_read || avs_write) && !avs_waitrequest;
   assign st_w1c  = bus_go && avs_write && (avs_address == FLD_OFS_STAT1);
   assign stop_off = stop_mode_in && !cfg.dbg && !cfg.osten;
   assign engaged  = ((cfg.csel == FLD_CSEL_EXT) || (cfg.csel == FLD_CSEL_INT)) && !stop_off;
   assign next_ctrl = avs_writedata;
   // Pulses this cycle included so a tick never drops the last edge
   assign next_err = 16'(signed'({4'h0, pulse_cnt} + {15'h0, osc_pulse_in}))
                   - 16'(signed'({9'h0, cfg.mul}));

   // Lock and unlock window comparators, limits fixed at build time
   fld_window_cmp u_lock_win
   (
      .value_in   (count_err),
      .min_in     (FLD_LOCK_MIN),
      .max_in     (FLD_LOCK_MAX),
      .inside_out (in_lock_win)
   );
   fld_window_cmp u_unlock_win
   (
      .value_in   (count_err),
      .min_in     (FLD_UNLOCK_MIN),
      .max_in     (FLD_UNLOCK_MAX),
      .inside_out (in_unlock_win)
   );

   // A write that changes the factor, select, or trim in internal engaged mode
   always_comb
   begin
      expected_loss = 1'b0;
      if (bus_go && avs_write && (avs_address == FLD_OFS_CTRL))
      begin
         if (next_ctrl[FLD_CTRL_MUL_LSB +: 7] != cfg.mul)
            expected_loss = 1'b1;
         if (next_ctrl[FLD_CTRL_CSEL_LSB +: 2] != cfg.csel)
            expected_loss = 1'b1;
         if ((cfg.csel == FLD_CSEL_INT) && (next_ctrl[FLD_CTRL_TRIM_LSB +: 8] != cfg.trim))
            expected_loss = 1'b1;
      end
   end

   assign unexpected_loss = (state == FLD_LOCKED) && engaged && sample_valid
                          && !in_unlock_win && !expected_loss;
   assign wake_loss  = stop_d && !stop_mode_in && stop_wake_lol;
   assign lost_set   = unexpected_loss || wake_loss;
   // Clear only after status one was read and with induced reset off
   assign lost_clear = st_w1c && avs_writedata[FLD_ST_IRQF_BIT]
                     && stat_read_armed && !cfg.lrsen;

   // Pulse counter and subtractor, one error per comparison cycle
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pulse_cnt    <= 12'h000;
         count_err    <= 16'sh0000;
         sample_valid <= 1'b0;
      end
      else if (ref_tick_in)
      begin
         pulse_cnt    <= 12'h000;
         count_err    <= next_err;
         sample_valid <= engaged;
      end
      else
      begin
         // Saturate rather than wrap so a runaway oscillator stays outside
         if (osc_pulse_in && (pulse_cnt != 12'hFFF))
            pulse_cnt <= pulse_cnt + 12'h001;
         sample_valid <= 1'b0;
      end
   end

   // Lock state machine
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state        <= FLD_IDLE;
         in_lock_run  <= 4'h0;
         first_locked <= 1'b0;
      end
      else
      begin
         case (state)
            FLD_IDLE:
            begin
               in_lock_run <= 4'h0;
               if (engaged)
               begin
                  state        <= FLD_UNLOCKED;
                  first_locked <= 1'b0;
               end
            end
            FLD_UNLOCKED:
            begin
               if (!engaged)
                  state <= FLD_IDLE;
               else if (expected_loss)
                  in_lock_run <= 4'h0;
               else if (sample_valid)
               begin
                  if (!in_lock_win)
                     in_lock_run <= 4'h0;
                  else if (in_lock_run == FLD_LOCK_SAMPLES - 4'h1)
                  begin
                     state        <= FLD_LOCKED;
                     in_lock_run  <= 4'h0;
                     first_locked <= 1'b1;
                  end
                  else
                     in_lock_run <= in_lock_run + 4'h1;
               end
            end
            FLD_LOCKED:
            begin
               // Stop-off drops lock here; status untouched
               if (!engaged)
                  state <= FLD_IDLE;
               else if (expected_loss || unexpected_loss)
                  state <= FLD_UNLOCKED;
            end
            default:
               state <= FLD_IDLE;
         endcase
      end
   end

   // Loop filter: every sample while unlocked, four-sample mean when locked
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         filter_value_out <= 16'sh0000;
         avg_acc          <= 18'sh00000;
         avg_cnt          <= 2'h0;
      end
      else if (state != FLD_LOCKED)
      begin
         avg_acc <= 18'sh00000;
         avg_cnt <= 2'h0;
         if (sample_valid && (state == FLD_UNLOCKED))
            filter_value_out <= count_err;
      end
      else if (sample_valid)
      begin
         if (avg_cnt == FLD_AVG_LAST)
         begin
            // Arithmetic shift keeps the sign of the mean
            filter_value_out <= 16'((avg_acc + 18'(count_err)) >>> 2);
            avg_acc          <= 18'sh00000;
            avg_cnt          <= 2'h0;
         end
         else
         begin
            avg_acc <= avg_acc + 18'(count_err);
            avg_cnt <= avg_cnt + 2'h1;
         end
      end
   end

   // Output clock divider: 2R until first lock, R afterwards
   always_comb
   begin
      div_target = first_locked ? {1'b0, cfg.rfd} : {cfg.rfd, 1'b0};
      if (div_target == 9'h000)
         div_target = 9'h001;
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         div_cnt                    <= 9'h000;
         generated_output_clock_out <= 1'b0;
         half_rate_out              <= 1'b1;
      end
      else
      begin
         half_rate_out              <= !first_locked;
         generated_output_clock_out <= 1'b0;
         if (osc_pulse_in)
         begin
            if (div_cnt >= div_target - 9'h001)
            begin
               div_cnt                    <= 9'h000;
               generated_output_clock_out <= 1'b1;
            end
            else
               div_cnt <= div_cnt + 9'h001;
         end
      end
   end

   // Stop tracking for the debug-dropped-in-stop case
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         stop_d         <= 1'b0;
         stop_dbg_armed <= 1'b0;
         stop_wake_lol  <= 1'b0;
      end
      else
      begin
         stop_d <= stop_mode_in;
         if (!stop_mode_in)
         begin
            stop_dbg_armed <= 1'b0;
            stop_wake_lol  <= stop_d ? 1'b0 : stop_wake_lol;
         end
         else if (!stop_d)
            stop_dbg_armed <= cfg.dbg;
         else if (stop_dbg_armed && !cfg.dbg)
            stop_wake_lol <= 1'b1;
      end
   end

   // Loss-of-lock status and induced reset request
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         lost                    <= 1'b0;
         loss_of_lock_status_out <= 1'b0;
         lol_reset_out           <= 1'b0;
         stat_read_armed         <= 1'b0;
      end
      else
      begin
         // Set wins over a clear in the same cycle
         if (lost_set)
            lost <= 1'b1;
         else if (lost_clear)
            lost <= 1'b0;
         loss_of_lock_status_out <= lost_set || (lost && !lost_clear);
         lol_reset_out           <= lost_set && cfg.lrsen;
         if (bus_go && avs_read && (avs_address == FLD_OFS_STAT1))
            stat_read_armed <= 1'b1;
         else if (lost_clear)
            stat_read_armed <= 1'b0;
      end
   end

   // Sticky event bits, mask and interrupt line
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         stat    <= 2'h0;
         irq_out <= 1'b0;
      end
      else
      begin
         stat[FLD_ST_IRQF_BIT] <= lost_set ||
            (stat[FLD_ST_IRQF_BIT] && !(st_w1c && avs_writedata[FLD_ST_IRQF_BIT]));
         stat[FLD_ST_LOCKE_BIT] <= (state == FLD_UNLOCKED && sample_valid && in_lock_win
            && in_lock_run == FLD_LOCK_SAMPLES - 4'h1 && engaged && !expected_loss) ||
            (stat[FLD_ST_LOCKE_BIT] && !(st_w1c && avs_writedata[FLD_ST_LOCKE_BIT]));
         irq_out <= |(stat & mask);
      end
   end

   // Lock indicator follows the state, cleared on stop-off or expected loss
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         lock_out <= 1'b0;
      else
         // Loss drops the indicator at the same edge that raises the status
         lock_out <= (state == FLD_LOCKED) && engaged && !expected_loss
                     && !unexpected_loss;
   end

   // Avalon-MM slave: one wait cycle per access, then completes
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         ctrl            <= FLD_CTRL_RST;
         mask            <= FLD_MASK_RST;
      end
      else
      begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (bus_go && avs_write && (avs_address == FLD_OFS_CTRL))
            ctrl <= next_ctrl & 32'hFF1F_FF7F;                              // Reserved bits stay zero
         if (bus_go && avs_write && (avs_address == FLD_OFS_MASK))
            mask <= avs_writedata[1:0];
         // Read data prepared during the wait cycle, valid at completion
         if (avs_read && avs_waitrequest)
         begin
            case (avs_address)
               FLD_OFS_CTRL:
                  avs_readdata <= ctrl;
               FLD_OFS_STAT1:
                  avs_readdata <= {count_err, 11'h000, half_rate_out, lost,
                                   lock_out, stat};
               FLD_OFS_MASK:
                  avs_readdata <= {30'h0, mask};
               default:
                  avs_readdata <= 32'h0000_0000;                             // Unmapped reads zero
            endcase
         end
      end
   end

endmodule : fld_lock_detector
`default_nettype wire

// File: rtl/fld_pkg.sv
// Constants and carrier types shared by the lock detector files
package fld_pkg;

   // Register byte offsets
   localparam logic [3:0] FLD_OFS_CTRL   = 4'h0;
   localparam logic [3:0] FLD_OFS_STAT1  = 4'h4;
   localparam logic [3:0] FLD_OFS_MASK   = 4'h8;

   // Control register field positions
   localparam int FLD_CTRL_MUL_LSB   = 0;   // Multiply factor, 7 bits
   localparam int FLD_CTRL_CSEL_LSB  = 8;   // Clock select, 2 bits
   localparam int FLD_CTRL_TRIM_LSB  = 10;  // Trim, 8 bits
   localparam int FLD_CTRL_LRSEN_BIT = 18;  // Loss-of-lock reset enable
   localparam int FLD_CTRL_DBG_BIT   = 19;  // Debug mode enable
   localparam int FLD_CTRL_OSTEN_BIT = 20;  // Oscillator stop enable
   localparam int FLD_CTRL_RFD_LSB   = 24;  // Output divide factor, 8 bits

   // Status register one field positions
   localparam int FLD_ST_IRQF_BIT  = 0;   // Interrupt flag: unexpected loss of lock
   localparam int FLD_ST_LOCKE_BIT = 1;   // Sticky event: lock reached
   localparam int FLD_ST_LOCK_BIT  = 2;   // Live lock indicator
   localparam int FLD_ST_LOST_BIT  = 3;   // Loss-of-lock status
   localparam int FLD_ST_DIV2_BIT  = 4;   // Output runs at half rate
   localparam int FLD_ST_ERR_LSB   = 16;  // Last count error, 16 bits

   // Reset values
   localparam logic [31:0] FLD_CTRL_RST = 32'h0100_0020;
   localparam logic [1:0]  FLD_MASK_RST = 2'h0;

   // Clock select encodings
   localparam logic [1:0] FLD_CSEL_SELF = 2'h0;
   localparam logic [1:0] FLD_CSEL_INT  = 2'h1;
   localparam logic [1:0] FLD_CSEL_BYP  = 2'h2;
   localparam logic [1:0] FLD_CSEL_EXT  = 2'h3;

   // Lock detector limits and sample count
   localparam logic signed [15:0] FLD_LOCK_MIN   = -16'sd2;
   localparam logic signed [15:0] FLD_LOCK_MAX   = 16'sd2;
   localparam logic signed [15:0] FLD_UNLOCK_MIN = -16'sd8;
   localparam logic signed [15:0] FLD_UNLOCK_MAX = 16'sd8;
   localparam logic [3:0]         FLD_LOCK_SAMPLES = 4'h4;
   localparam logic [1:0]         FLD_AVG_LAST     = 2'h3;  // Four samples per update

   // Detector states
   typedef enum logic [1:0] {
      FLD_IDLE,
      FLD_UNLOCKED,
      FLD_LOCKED
   } fld_state_e;

   // Fields decoded from the control register
   typedef struct packed {
      logic [7:0] rfd;
      logic       osten;
      logic       dbg;
      logic       lrsen;
      logic [7:0] trim;
      logic [1:0] csel;
      logic [6:0] mul;
   } fld_ctrl_s;

endpackage : fld_pkg

// File: rtl/fld_window_cmp.sv
// Strict window comparator for signed count errors
`timescale 1ns/1ps
`default_nettype none
module fld_window_cmp
   import fld_pkg::*;
(
   input  wire logic signed [15:0] value_in,   // Count error
   input  wire logic signed [15:0] min_in,     // Lower limit, excluded
   input  wire logic signed [15:0] max_in,     // Upper limit, excluded
   output logic                    inside_out  // Strictly inside the window
);
   // Both bounds excluded so a value on the limit counts as outside
   assign inside_out = (value_in > min_in) && (value_in < max_in);
endmodule : fld_window_cmp
`default_nettype wire

// File: verification/fld_lock_detector_props.sv
// Port-level concurrent checks for the lock detector
`timescale 1ns/1ps
`default_nettype none
module fld_lock_detector_props
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic ref_tick_in,
   input wire logic stop_mode_in,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic lock_out,
   input wire logic loss_of_lock_status_out,
   input wire logic generated_output_clock_out,
   input wire logic half_rate_out,
   input wire logic lol_reset_out,
   input wire logic irq_out
);
   logic [2:0] ev_sr;  // Recent ticks, stops or writes: causes of a lock drop
   logic [2:0] wr_sr;  // Recent accepted writes
   // History lets a drop lag its cause by a few cycles
   always_ff @(posedge sys_clk_in or negedge nrst_in)
      if (!nrst_in)
      begin
         ev_sr <= 3'h0;
         wr_sr <= 3'h0;
      end
      else
      begin
         ev_sr <= {ev_sr[1:0], ref_tick_in | stop_mode_in | avs_write};
         wr_sr <= {wr_sr[1:0], avs_write & ~avs_waitrequest};
      end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   property p_wait_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("no answer");
   property p_wait_idle;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("long answer");
   property p_lock_rise;
      $rose(lock_out) |-> $past(ref_tick_in, 3);
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock off tick");
   property p_lock_fall;
      $fell(lock_out) |-> ev_sr != 3'h0;
   endproperty
   a_lock_fall: assert property (p_lock_fall) else $error("lock drop uncaused");
   property p_half;
      lock_out |-> !half_rate_out;
   endproperty
   a_half: assert property (p_half) else $error("half rate locked");
   property p_div2;
      half_rate_out && generated_output_clock_out |=> !generated_output_clock_out;
   endproperty
   a_div2: assert property (p_div2) else $error("half rate pulse");
   property p_lost_rise;
      $rose(loss_of_lock_status_out) |-> !lock_out;
   endproperty
   a_lost_rise: assert property (p_lost_rise) else $error("loss status while locked");
   property p_lost_fall;
      $fell(loss_of_lock_status_out) |-> wr_sr[1:0] != 2'h0;
   endproperty
   a_lost_fall: assert property (p_lost_fall) else $error("loss status dropped");
   property p_lolrst;
      lol_reset_out |=> !lol_reset_out;
   endproperty
   a_lolrst: assert property (p_lolrst) else $error("reset pulse long");
   c_lock: cover property ($rose(lock_out));
   c_loss_of_lock_status: cover property ($rose(loss_of_lock_status_out));
   c_irq: cover property ($rose(irq_out));
endmodule : fld_lock_detector_props
`default_nettype wire

// File: verification/fld_ref_model.sv
// Oscillator pulse and reference tick source
`timescale 1ns/1ps
`default_nettype none
module fld_ref_model
#(
   parameter int PERIOD = 48  // System cycles per comparison cycle
)
(
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic [5:0] pulses_in,     // Pulses per comparison cycle
   output logic            osc_pulse_out,
   output logic            ref_tick_out
);
   logic [5:0] cyc;    // Place in the comparison cycle
   logic [5:0] n_cur;  // Latched at cycle start so no cycle is mixed
   // Free-running comparison cycle
   always_ff @(posedge clk_in or negedge nrst_in)
      if (!nrst_in)
      begin
         cyc <= 6'h0;
         n_cur <= 6'h0;
      end
      else
      begin
         cyc <= (cyc == 6'(PERIOD - 1)) ? 6'h0 : cyc + 6'h1;
         if (cyc == 6'h0)
            n_cur <= pulses_in;
      end
   // Pulses fill cycles 1 to n_cur, so they reach the tick once n_cur is PERIOD - 1 or more
   assign osc_pulse_out = (cyc != 6'h0) && (cyc <= n_cur);
   assign ref_tick_out = (cyc == 6'(PERIOD - 1));
endmodule : fld_ref_model
`default_nettype wire

// File: verification/tb_fld_lock_detector.sv
// Self-checking bench for the lock detector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module tb_fld_lock_detector
   import fld_pkg::*;
;
   logic        sys_clk_in, nrst_in, osc_pulse_in, ref_tick_in, stop_mode_in;
   logic [3:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        lock_out, loss_of_lock_status_out, generated_output_clock_out;
   logic        half_rate_out, lol_reset_out, irq_out;
   logic signed [15:0] filter_value_out;
   logic [5:0]  pulses;  // Oscillator pulses per comparison cycle
   int          n_mismatch, comparisons;
   int          n_lrst;  // Induced reset request pulses seen
   fld_lock_detector dut (.sys_clk_in, .nrst_in, .osc_pulse_in, .ref_tick_in,
      .stop_mode_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .lock_out, .loss_of_lock_status_out,
      .generated_output_clock_out, .half_rate_out, .filter_value_out,
      .lol_reset_out, .irq_out);
   fld_ref_model #(.PERIOD(48)) u_ref (.clk_in(sys_clk_in), .nrst_in(nrst_in),
      .pulses_in(pulses), .osc_pulse_out(osc_pulse_in), .ref_tick_out(ref_tick_in));
   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   // One bus access; request held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do
      begin
         @(posedge sys_clk_in);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         n_mismatch++;  // A missing answer counts as a mismatch
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // Bounded wait on the lock indicator
   task wait_lock(input logic v);
      int n;
      n = 0;
      while (lock_out !== v && n < 1000)
      begin
         @(posedge sys_clk_in);
         n++;
      end
      if (n >= 1000)
         n_mismatch++;  // Indicator never reached the wanted level
   endtask : wait_lock
   task t_reset;
      bus(0, FLD_OFS_CTRL, 0);
      `CHK(q, FLD_CTRL_RST, "ctrl reset")
      bus(0, FLD_OFS_MASK, 0);
      `CHK(q[1:0], FLD_MASK_RST, "mask reset")
      bus(1, 4'hC, 32'hFFFF_FFFF);
      bus(0, 4'hC, 0);
      `CHK(q, 32'h0, "unmapped")
      bus(0, FLD_OFS_STAT1, 0);
      `CHK(q[4:0], 5'h10, "status reset")
      $display("t_reset done");
   endtask : t_reset
   task t_lock;
      pulses <= 6'd35;  // Error 3: outside the lock window
      bus(1, FLD_OFS_CTRL, 32'h0100_0320);
      repeat (300) @(posedge sys_clk_in);
      `CHK(lock_out, 1'b0, "locked early")
      `CHK(half_rate_out, 1'b1, "full rate early")
      pulses <= 6'd32;
      wait_lock(1'b1);
      `CHK(lock_out, 1'b1, "no lock")
      `CHK(half_rate_out, 1'b0, "still half")
      bus(0, FLD_OFS_STAT1, 0);
      `CHK(q[4:0], 5'h06, "lock status")
      `CHK(q[31:16], 16'h0000, "lock error")
      $display("t_lock done");
   endtask : t_lock
   task t_loss;
      pulses <= 6'd37;  // Error 5: inside the unlock window
      // Long enough for a whole four-sample group of error 5
      repeat (500) @(posedge sys_clk_in);
      `CHK(lock_out, 1'b1, "drift unlock")
      `CHK(filter_value_out, 16'sd5, "filter mean")
      pulses <= 6'd45;  // Error 13: outside the unlock window
      wait_lock(1'b0);
      `CHK(loss_of_lock_status_out, 1'b1, "no loss status")
      `CHK(irq_out, 1'b0, "masked irq")
      bus(1, FLD_OFS_MASK, 32'h1);
      repeat (3) @(posedge sys_clk_in);
      `CHK(irq_out, 1'b1, "no irq")
      bus(0, FLD_OFS_STAT1, 0);
      `CHK(q[4:0], 5'h0B, "loss status")
      `CHK(q[31:16], 16'h000D, "loss error")
      bus(1, FLD_OFS_STAT1, 32'h1);
      repeat (3) @(posedge sys_clk_in);
      `CHK(loss_of_lock_status_out, 1'b0, "loss status kept")
      `CHK(irq_out, 1'b0, "irq kept")
      $display("t_loss done");
   endtask : t_loss
   task t_expect;
      pulses <= 6'd32;
      wait_lock(1'b1);
      bus(1, FLD_OFS_CTRL, 32'h0100_0321);
      repeat (4) @(posedge sys_clk_in);
      `CHK(lock_out, 1'b0, "lock kept")
      `CHK(loss_of_lock_status_out, 1'b0, "loss status on change")
      wait_lock(1'b1);
      `CHK(lock_out, 1'b1, "no relock")
      $display("t_expect done");
   endtask : t_expect
   task t_stop;
      stop_mode_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      `CHK(lock_out, 1'b0, "lock in stop")
      `CHK(loss_of_lock_status_out, 1'b0, "loss status in stop")
      stop_mode_in <= 1'b0;
      wait_lock(1'b1);
      `CHK(lock_out, 1'b1, "no wake lock")
      $display("t_stop done");
   endtask : t_stop
   // Counts induced reset requests; pulses last one cycle so each is seen once
   always @(posedge sys_clk_in)
      if (lol_reset_out === 1'b1)
         n_lrst++;
   task t_induced;
      bus(1, FLD_OFS_CTRL, 32'h0104_0321);  // Same loop settings, induced reset on
      repeat (2) @(posedge sys_clk_in);
      `CHK(lock_out, 1'b1, "lock lost on enable write")
      pulses <= 6'd45;  // Error 12: outside the unlock window
      wait_lock(1'b0);
      `CHK(loss_of_lock_status_out, 1'b1, "no loss status")
      bus(0, FLD_OFS_STAT1, 0);
      bus(1, FLD_OFS_STAT1, 32'h1);
      repeat (3) @(posedge sys_clk_in);
      `CHK(loss_of_lock_status_out, 1'b1, "cleared with reset on")
      `CHK(n_lrst, 1, "induced reset pulses")
      $display("t_induced done");
   endtask : t_induced
   task complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      {nrst_in, stop_mode_in, avs_read, avs_write} = 4'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      pulses = 6'd32;
      repeat (20) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_lock();
      t_loss();
      t_expect();
      t_stop();
      t_induced();
      complete_run();
   end
endmodule : tb_fld_lock_detector
bind fld_lock_detector fld_lock_detector_props u_props (.sys_clk_in, .nrst_in,
   .ref_tick_in, .stop_mode_in, .avs_read, .avs_write, .avs_waitrequest, .lock_out,
   .loss_of_lock_status_out, .generated_output_clock_out, .half_rate_out,
   .lol_reset_out, .irq_out);
`default_nettype wire
